// File: rtl/tpc_pkg.sv
package tpc_pkg;
   // ************************************************************
   // register map (byte addresses, one word each)
   // ************************************************************
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_COUNT = 12'h004;
   localparam logic [11:0] ADDR_RELOAD = 12'h008;
   localparam logic [11:0] ADDR_PWM = 12'h00c;
   localparam logic [11:0] ADDR_STATUS = 12'h010;

   // ctrl field positions
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_POL_BIT = 1;
   localparam int CTRL_MODE_LSB = 4;
   localparam int CTRL_PRE_LSB = 8;
   localparam int CTRL_DB_LSB = 16;

   // ************************************************************
   // counter constants
   // ************************************************************
   localparam logic [15:0] CNT_RESTART = 16'h0001;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_RST_VAL = 16'h0001;
   localparam logic [15:0] RELOAD_RST_VAL = 16'hffff;
   localparam logic [7:0] DEADBAND_MAX = 8'h80;

   typedef enum logic [2:0] {
      TPC_MODE_CMPCNT = 3'h0,
      TPC_MODE_PWM1 = 3'h1,
      TPC_MODE_PWM2 = 3'h2,
      TPC_MODE_CAP = 3'h3,
      TPC_MODE_CAPRST = 3'h4,
      TPC_MODE_CAPCMP = 3'h5
   } tpc_mode_t;

   // control word as seen by the core
   typedef struct packed {
      logic enable;
      logic inputOutputPolarity;
      logic [2:0] mode;
      logic [2:0] prescaleSel;
      logic [7:0] deadbandDelayField;
   } tpc_ctrl_t;

   // events reported by the core
   typedef struct packed {
      logic reloadHit;
      logic captureHit;
   } tpc_evt_t;
endpackage

// File: rtl/tpc_edge_sync.sv
`timescale 1ns/1ps
// ************************************************************
// three-flop synchroniser with qualified edge output
// ************************************************************
module tpc_edge_sync
   import tpc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic pinIn,
   input wire logic polarity,
   output logic edgePulse
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic level_r;

   // first flop feeds only the second
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else begin
         s1_r <= pinIn;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // settled level changes only when stages two and three agree
   always_ff @(posedge clk) begin
      if (rst) begin
         level_r <= 1'b0;
      end else if (s2_r == s3_r) begin
         level_r <= s3_r;
      end
   end

   // polarity 0 takes rising, 1 takes falling
   assign edgePulse = (s2_r == s3_r) && (s3_r != level_r) && (s3_r == ~polarity);
endmodule // tpc_edge_sync

// File: rtl/tpc_deadband.sv
`timescale 1ns/1ps
// ************************************************************
// rising-edge delay for one output of the pair
// ************************************************************
module tpc_deadband
   import tpc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic rawIn,
   input wire logic [7:0] delayCycles,
   output logic delayedOut
);
   logic [7:0] cnt_r;
   logic out_r;

   // falls pass at once, rises wait delayCycles clocks
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= 8'h00;
         out_r <= 1'b0;
      end else if (!rawIn) begin
         cnt_r <= 8'h00;
         out_r <= 1'b0;
      end else if (!out_r) begin
         if (cnt_r >= delayCycles) begin
            out_r <= 1'b1;
         end else begin
            cnt_r <= cnt_r + 8'h01;
         end
      end
   end

   assign delayedOut = out_r;
endmodule // tpc_deadband

// File: rtl/tpc_timer.sv
`timescale 1ns/1ps
// ************************************************************
// apb timer with pwm, capture and comparator-count modes
// ************************************************************
// Operation
// - comparator counter mode counts comparator output transitions only
// - polarity picks rising or falling comparator edge
// - prescaler bypassed in comparator counter mode
// - single pwm: output toggles when count equals pwm value
// - pwm modes: at reload, flag event, load 0001h, continue
// - output starts at polarity level, flips on match, restores at reload
// - polarity 0 high match-to-reload; polarity 1 high reload-to-match
// - preloaded start count used only for first period
// - dual pwm drives signal and its complement
// - deadband delays rising edges of both outputs by 0..128 clocks
// - capture mode wraps ffffh to 0000h
// - capture copies count to pwm register, flags event, keeps counting
// - capture mode reload flags event without reloading
// - capture restart: capture stores count, flags, restarts at 0001h
// - capture restart: reload without capture flags, restarts at 0001h
// - capture/compare waits for first input edge before counting
// - later edges capture, flag, restart at 0001h
// - compare hit without capture flags and restarts at 0001h
module tpc_timer
   import tpc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic timerIn,
   input wire logic cmpOut,
   output logic timerOut,
   output logic complementary_output
);
   tpc_ctrl_t ctrl_r;
   logic [15:0] count_r;
   logic [15:0] reload_r;
   logic [15:0] pwm_r;
   logic [1:0] status_r;
   logic [7:0] pre_r;
   logic pwmLvl_r;
   logic armed_r;
   logic tick;
   logic cmpEdge;
   logic inEdge;
   logic wrEn;
   logic countWr;
   logic atReload;
   logic atMatch;
   logic capEvt;
   logic advance;
   logic [15:0] countNext;
   logic [7:0] preTop;
   logic dbHigh;
   logic dbLow;
   tpc_evt_t evt;

   // decode an apb address against one register
   function automatic logic hitAddr(input logic [11:0] a, input logic [11:0] r);
      hitAddr = (a == r);
   endfunction

   // ************************************************************
   // apb slave: zero wait states, unmapped addresses flag an error
   // ************************************************************
   assign pready = 1'b1;
   assign wrEn = psel && penable && pwrite;
   assign countWr = wrEn && hitAddr(paddr, ADDR_COUNT);
   always_comb begin
      pslverr = psel && penable && !(hitAddr(paddr, ADDR_CTRL) || hitAddr(paddr, ADDR_COUNT)
         || hitAddr(paddr, ADDR_RELOAD) || hitAddr(paddr, ADDR_PWM) || hitAddr(paddr, ADDR_STATUS));
   end

   // control word
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_r <= '0;
      end else if (wrEn && hitAddr(paddr, ADDR_CTRL)) begin
         ctrl_r.enable <= pwdata[CTRL_EN_BIT];
         ctrl_r.inputOutputPolarity <= pwdata[CTRL_POL_BIT];
         ctrl_r.mode <= pwdata[CTRL_MODE_LSB +: 3];
         ctrl_r.prescaleSel <= pwdata[CTRL_PRE_LSB +: 3];
         // values above the top are held at the top
         ctrl_r.deadbandDelayField <= (pwdata[CTRL_DB_LSB +: 8] > DEADBAND_MAX) ? DEADBAND_MAX
            : pwdata[CTRL_DB_LSB +: 8];
      end
   end

   // reload/compare value
   always_ff @(posedge clk) begin
      if (rst) begin
         reload_r <= RELOAD_RST_VAL;
      end else if (wrEn && hitAddr(paddr, ADDR_RELOAD)) begin
         reload_r <= pwdata[15:0];
      end
   end

   // read mux, registered so data comes from flops in the access phase
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            ADDR_CTRL: prdata <= {8'h00, ctrl_r.deadbandDelayField, 5'h00, ctrl_r.prescaleSel,
               1'b0, ctrl_r.mode, 2'h0, ctrl_r.inputOutputPolarity, ctrl_r.enable};
            ADDR_COUNT: prdata <= {16'h0000, count_r};
            ADDR_RELOAD: prdata <= {16'h0000, reload_r};
            ADDR_PWM: prdata <= {16'h0000, pwm_r};
            ADDR_STATUS: prdata <= {30'h0000_0000, status_r};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ************************************************************
   // edge inputs
   // ************************************************************
   tpc_edge_sync u_cmpSync (
      .clk(clk),
      .rst(rst),
      .pinIn(cmpOut),
      .polarity(ctrl_r.inputOutputPolarity),
      .edgePulse(cmpEdge)
   );

   tpc_edge_sync u_inSync (
      .clk(clk),
      .rst(rst),
      .pinIn(timerIn),
      .polarity(ctrl_r.inputOutputPolarity),
      .edgePulse(inEdge)
   );

   // ************************************************************
   // prescaler: divide by 2^sel
   // ************************************************************
   assign preTop = 8'((9'h001 << ctrl_r.prescaleSel) - 9'h001);
   always_ff @(posedge clk) begin
      if (rst || !ctrl_r.enable) begin
         pre_r <= 8'h00;
      end else if (pre_r >= preTop) begin
         pre_r <= 8'h00;
      end else begin
         pre_r <= pre_r + 8'h01;
      end
   end
   assign tick = ctrl_r.enable && (pre_r >= preTop);

   // ************************************************************
   // counter core
   // ************************************************************
   assign atReload = (count_r == reload_r);
   assign atMatch = (count_r == pwm_r);
   assign capEvt = ctrl_r.enable && inEdge && (ctrl_r.mode == TPC_MODE_CAP || ctrl_r.mode == TPC_MODE_CAPRST
      || (ctrl_r.mode == TPC_MODE_CAPCMP && armed_r));
   // comparator mode counts only its own edges, no prescale
   assign advance = (ctrl_r.mode == TPC_MODE_CMPCNT) ? (ctrl_r.enable && cmpEdge)
      : (tick && (ctrl_r.mode != TPC_MODE_CAPCMP || armed_r));

   // next count and event flags per mode
   always_comb begin
      countNext = count_r;
      evt = '0;
      case (ctrl_r.mode)
         TPC_MODE_CAP: begin
            if (capEvt) begin
               evt.captureHit = 1'b1;
            end
            if (advance) begin
               evt.reloadHit = atReload;
               countNext = count_r + 16'h0001;
            end
         end
         TPC_MODE_CAPRST, TPC_MODE_CAPCMP: begin
            if (capEvt) begin
               evt.captureHit = 1'b1;
               countNext = CNT_RESTART;
            end else if (advance && atReload) begin
               evt.reloadHit = 1'b1;
               countNext = CNT_RESTART;
            end else if (advance) begin
               countNext = count_r + 16'h0001;
            end
         end
         default: begin
            // pwm and comparator count: wrap to 0001h at reload
            if (advance && atReload) begin
               evt.reloadHit = 1'b1;
               countNext = CNT_RESTART;
            end else if (advance) begin
               countNext = count_r + 16'h0001;
            end
         end
      endcase
   end

   // software write of the count sets the first period only
   always_ff @(posedge clk) begin
      if (rst) begin
         count_r <= CNT_RST_VAL;
      end else if (countWr) begin
         count_r <= pwdata[15:0];
      end else begin
         count_r <= countNext;
      end
   end

   // capture/compare arms on the first input edge
   always_ff @(posedge clk) begin
      if (rst || !ctrl_r.enable || ctrl_r.mode != TPC_MODE_CAPCMP) begin
         armed_r <= 1'b0;
      end else if (inEdge) begin
         armed_r <= 1'b1;
      end
   end

   // pwm value register, also the capture target
   always_ff @(posedge clk) begin
      if (rst) begin
         pwm_r <= 16'h0000;
      end else if (evt.captureHit) begin
         pwm_r <= count_r;
      end else if (wrEn && hitAddr(paddr, ADDR_PWM)) begin
         pwm_r <= pwdata[15:0];
      end
   end

   // sticky event status, write one to clear; a new event wins the clear
   always_ff @(posedge clk) begin
      if (rst) begin
         status_r <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (evt[i]) begin
               status_r[i] <= 1'b1;
            end else if (wrEn && hitAddr(paddr, ADDR_STATUS) && pwdata[i]) begin
               status_r[i] <= 1'b0;
            end
         end
      end
   end

   // ************************************************************
   // pwm output level
   // ************************************************************
   always_ff @(posedge clk) begin
      if (rst || !ctrl_r.enable) begin
         pwmLvl_r <= ctrl_r.inputOutputPolarity;
      end else if (evt.reloadHit) begin
         pwmLvl_r <= ctrl_r.inputOutputPolarity;
      end else if (advance && atMatch) begin
         pwmLvl_r <= ~ctrl_r.inputOutputPolarity;
      end
   end

   // dual mode: both phases delayed on their rising edges
   tpc_deadband u_dbHigh (
      .clk(clk),
      .rst(rst),
      .rawIn(pwmLvl_r),
      .delayCycles(ctrl_r.deadbandDelayField),
      .delayedOut(dbHigh)
   );

   tpc_deadband u_dbLow (
      .clk(clk),
      .rst(rst),
      .rawIn(~pwmLvl_r),
      .delayCycles(ctrl_r.deadbandDelayField),
      .delayedOut(dbLow)
   );

   always_comb begin
      if (ctrl_r.mode == TPC_MODE_PWM2) begin
         timerOut = dbHigh;
         complementary_output = dbLow;
      end else begin
         timerOut = pwmLvl_r;
         complementary_output = 1'b0;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   property p_reload_restart;
      @(posedge clk) disable iff (rst)
      (ctrl_r.mode == TPC_MODE_PWM1 && advance && atReload && !countWr) |=> (count_r == CNT_RESTART);
   endproperty
   a_reload_restart: assert property (p_reload_restart) else $error("pwm reload did not restart");

   property p_match_level;
      @(posedge clk) disable iff (rst)
      (ctrl_r.enable && ctrl_r.mode == TPC_MODE_PWM1 && advance && atMatch && !atReload && $stable(ctrl_r))
         |=> (timerOut == ~$past(ctrl_r.inputOutputPolarity));
   endproperty
   a_match_level: assert property (p_match_level) else $error("pwm match level wrong");

   property p_cap_store;
      @(posedge clk) disable iff (rst)
      evt.captureHit |=> (pwm_r == $past(count_r)) && status_r[0];
   endproperty
   a_cap_store: assert property (p_cap_store) else $error("capture not stored");

   property p_cap_wrap;
      @(posedge clk) disable iff (rst)
      (ctrl_r.mode == TPC_MODE_CAP && advance && count_r == 16'hffff && !countWr) |=> (count_r == CNT_ZERO);
   endproperty
   a_cap_wrap: assert property (p_cap_wrap) else $error("capture mode did not wrap");

   property p_caprst_restart;
      @(posedge clk) disable iff (rst)
      (ctrl_r.mode == TPC_MODE_CAPRST && capEvt && !countWr) |=> (count_r == CNT_RESTART);
   endproperty
   a_caprst_restart: assert property (p_caprst_restart) else $error("capture restart failed");

   property p_capcmp_hold;
      @(posedge clk) disable iff (rst)
      (ctrl_r.mode == TPC_MODE_CAPCMP && !armed_r && !countWr) |=> $stable(count_r);
   endproperty
   a_capcmp_hold: assert property (p_capcmp_hold) else $error("count moved before arming");

   property p_cmp_only;
      @(posedge clk) disable iff (rst)
      (ctrl_r.mode == TPC_MODE_CMPCNT && !cmpEdge && !countWr) |=> $stable(count_r);
   endproperty
   a_cmp_only: assert property (p_cmp_only) else $error("counted without comparator edge");

   property p_dual_gap;
      @(posedge clk) disable iff (rst)
      !(timerOut && complementary_output);
   endproperty
   a_dual_gap: assert property (p_dual_gap) else $error("both outputs active");
endmodule // tpc_timer

// File: testbench/tpc_pin_model.sv
`timescale 1ns/1ps
// ********************
// far-side pin driver
// ********************
module tpc_pin_model
   import tpc_pkg::*;
(
   input wire logic clk,
   input wire logic timerReq,
   input wire logic cmpReq,
   input wire logic slow,
   output logic timerIn,
   output logic cmpOut
);
   logic [1:0] tPipe_r = 2'b00;
   logic [1:0] cPipe_r = 2'b00;
   // pins follow requests after a clean clocked lag, so no glitches
   always_ff @(posedge clk) begin
      tPipe_r <= {tPipe_r[0], timerReq};
      cPipe_r <= {cPipe_r[0], cmpReq};
   end
   // slow mode mimics a sluggish source: one extra clock of lag
   assign timerIn = slow ? tPipe_r[1] : tPipe_r[0];
   assign cmpOut = slow ? cPipe_r[1] : cPipe_r[0];
endmodule // tpc_pin_model

// File: testbench/test_timer_pwm_capture_modes.sv
`timescale 1ns/1ps
module test_timer_pwm_capture_modes
   import tpc_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, timerOut, compOut, timerIn, cmpOut, err;
   logic timerReq = 1'b0, cmpReq = 1'b0, slow = 1'b0;
   int errorCnt = 0, checkCount = 0;

   // free-running 10 MHz clock
   always #50 clk = ~clk;

   tpc_timer uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timerIn(timerIn), .cmpOut(cmpOut), .timerOut(timerOut), .complementary_output(compOut));
   tpc_pin_model pins (.clk(clk), .timerReq(timerReq), .cmpReq(cmpReq), .slow(slow),
      .timerIn(timerIn), .cmpOut(cmpOut));

   // ********************
   // compare and bus tasks
   // ********************
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checkCount++;
      if (got !== exp) begin
         errorCnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // range compare; an unknown never lands inside
   task automatic chkIn(input string nm, input logic [31:0] lo, input logic [31:0] hi,
         input logic [31:0] got);
      checkCount++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         errorCnt++;
         $display("CHECK FAILED %s expected %h..%h seen %h", nm, lo, hi, got);
      end
   endtask
   // one apb transfer; waits on pready, no latency assumed
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // only the watchdog ends a wait that never gets an answer
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // control written disabled first so a polarity change cannot fake an edge
   task automatic cfg(input int mode, input int pol, input int pre, input int db,
         input logic [15:0] start, input logic [15:0] rel, input logic [15:0] pwm);
      logic [31:0] c;
      c = (db << 16) | (pre << 8) | (mode << 4) | (pol << 1);
      apb(1'b1, ADDR_CTRL, c);
      apb(1'b1, ADDR_COUNT, {16'h0, start});
      apb(1'b1, ADDR_RELOAD, {16'h0, rel});
      apb(1'b1, ADDR_PWM, {16'h0, pwm});
      apb(1'b1, ADDR_STATUS, 32'h3);
      apb(1'b1, ADDR_CTRL, c | 32'h1);
   endtask
   // pin level change, then room for synchroniser lag
   task automatic pin(input logic isCmp, input logic v);
      @(posedge clk);
      if (isCmp) cmpReq <= v;
      else timerReq <= v;
      repeat (8) @(posedge clk);
   endtask
   // high-time count over three whole 10-tick periods
   task automatic sampleOut(output int hiA, output int hiB, output int both);
      hiA = 0;
      hiB = 0;
      both = 0;
      repeat (30) begin
         @(negedge clk);
         hiA += (timerOut === 1'b1);
         hiB += (compOut === 1'b1);
         both += (timerOut === 1'b1 && compOut === 1'b1);
      end
   endtask
   // running restart mode with no capture: reload hit only
   task automatic noCapture;
      apb(1'b1, ADDR_RELOAD, 32'h28);
      apb(1'b1, ADDR_STATUS, 32'h3);
      repeat (60) @(posedge clk);
      apb(1'b0, ADDR_STATUS, 0);
      chk("reload flag only", 2, rd);
      apb(1'b0, ADDR_COUNT, 0);
      chkIn("restarted count", 1, 40, rd);
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checkCount, errorCnt);
      if (errorCnt == 0 && checkCount > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // watchdog: whole run needs well under 20k clocks
   initial begin
      repeat (30000) @(posedge clk);
      errorCnt++;
      conclude;
   end

   // ********************
   // test sequence
   // ********************
   initial begin
      int n, a, b, c0, p;
      logic [15:0] s;
      void'($urandom(32'h6f5f));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, ADDR_COUNT, 0);
      chk("count reset", 1, rd);
      apb(1'b0, ADDR_RELOAD, 0);
      chk("reload reset", 32'hffff, rd);
      apb(1'b0, 12'h020, 0);
      chk("unmapped err", 1, err);
      chk("unmapped data", 0, rd);
      $display("done reset");
      n = 2 + $urandom % 4;
      for (int pol = 0; pol < 2; pol++) begin
         cfg(0, pol, 3, 0, 16'h0001, 16'hffff, 16'h0);
         pin(1'b0, 1'b1);
         pin(1'b0, 1'b0);
         for (int i = 0; i < n; i++) begin
            pin(1'b1, 1'b1);
            apb(1'b0, ADDR_COUNT, 0);
            chk("cmp rise", 1 + i + (pol == 0), rd);
            pin(1'b1, 1'b0);
            apb(1'b0, ADDR_COUNT, 0);
            chk("cmp fall", 2 + i, rd);
         end
      end
      $display("done comparator count");
      for (int pol = 0; pol < 2; pol++) begin
         cfg(1, pol, 0, 0, 16'h0001, 16'h000a, 16'h0004);
         repeat (25) @(posedge clk);
         sampleOut(a, b, p);
         chk("pwm high", pol ? 12 : 18, a);
         apb(1'b0, ADDR_STATUS, 0);
         chk("pwm reload flag", 1, rd[1]);
         apb(1'b0, ADDR_COUNT, 0);
         chkIn("pwm count", 1, 10, rd);
      end
      cfg(1, 0, 0, 0, 16'h0007, 16'h000a, 16'h0004);
      sampleOut(a, b, p);
      chkIn("preload period", 12, 16, a);
      cfg(2, 0, 0, 2, 16'h0001, 16'h000a, 16'h0004);
      repeat (25) @(posedge clk);
      sampleOut(a, b, p);
      chk("dual main", 12, a);
      chk("dual comp", 6, b);
      chk("dual overlap", 0, p);
      // deadband above the top is held at the top
      apb(1'b1, ADDR_CTRL, 32'h00ff_0020);
      apb(1'b0, ADDR_CTRL, 0);
      chk("deadband clamp", 32'h0080_0020, rd);
      $display("done pwm");
      for (int pol = 0; pol < 2; pol++) begin
         cfg(3, pol, 0, 0, 16'h0001, 16'h001e, 16'h0);
         repeat (50) @(posedge clk);
         pin(1'b0, 1'b1);
         apb(1'b0, ADDR_STATUS, 0);
         chk("rise capture", pol == 0, rd[0]);
         pin(1'b0, 1'b0);
         apb(1'b0, ADDR_PWM, 0);
         p = rd;
         chkIn("capture value", 50, 80, rd);
         apb(1'b0, ADDR_STATUS, 0);
         chk("capture flags", 3, rd);
         apb(1'b0, ADDR_COUNT, 0);
         chkIn("count kept", p + 4, p + 40, rd);
      end
      s = 16'hffe0 + 16'($urandom % 8);
      cfg(3, 0, 0, 0, s, 16'hffff, 16'h0);
      repeat (40) @(posedge clk);
      apb(1'b0, ADDR_COUNT, 0);
      chkIn("wrap", 1, 32'h30, rd);
      for (int pre = 0; pre < 4; pre++) begin
         cfg(3, 0, pre, 0, 16'h0001, 16'hffff, 16'h0);
         apb(1'b0, ADDR_COUNT, 0);
         c0 = rd;
         repeat (40) @(posedge clk);
         apb(1'b0, ADDR_COUNT, 0);
         chkIn("prescale", c0 + 43 / (1 << pre) - 1, c0 + 43 / (1 << pre) + 1, rd);
      end
      $display("done capture");
      cfg(4, 0, 0, 0, 16'h0001, 16'h03e8, 16'h0);
      repeat (40) @(posedge clk);
      pin(1'b0, 1'b1);
      pin(1'b0, 1'b0);
      apb(1'b0, ADDR_PWM, 0);
      chkIn("restart capture", 40, 60, rd);
      apb(1'b0, ADDR_STATUS, 0);
      chk("restart flags", 1, rd);
      apb(1'b0, ADDR_COUNT, 0);
      chkIn("restart count", 1, 28, rd);
      noCapture;
      $display("done capture restart");
      slow <= 1'b1;
      cfg(5, 0, 0, 0, 16'h0001, 16'h03e8, 16'h0);
      repeat (40) @(posedge clk);
      apb(1'b0, ADDR_COUNT, 0);
      chk("held count", 1, rd);
      pin(1'b0, 1'b1);
      pin(1'b0, 1'b0);
      repeat (30) @(posedge clk);
      pin(1'b0, 1'b1);
      pin(1'b0, 1'b0);
      apb(1'b0, ADDR_PWM, 0);
      chkIn("second edge", 40, 60, rd);
      apb(1'b0, ADDR_COUNT, 0);
      chkIn("after capture", 1, 25, rd);
      noCapture;
      $display("done capture compare");
      conclude;
   end
endmodule // test_timer_pwm_capture_modes
